// file: hdl/fsr_pkg.sv
// Constants, field layout and carrier types for the status register block.
// Assumes a single core clock domain; link pins arrive unsynchronised.
package fsr_pkg;
  localparam logic [7:0] OP_READ_ONE  = 8'h05;
  localparam logic [7:0] OP_READ_TWO  = 8'h35;
  localparam logic [7:0] RST_ONE      = 8'h00;
  localparam logic [7:0] RST_TWO      = 8'h00;
  localparam logic [7:0] WMASK_ONE    = 8'hFC;
  localparam logic [7:0] WMASK_TWO    = 8'h7B;
  localparam int         B1_GUARD_LO  = 7;
  localparam int         B1_AREA_HI   = 6;
  localparam int         B1_AREA_LO   = 2;
  localparam int         B1_WPL       = 1;
  localparam int         B1_BUSY      = 0;
  localparam int         B2_ERASE_P   = 7;
  localparam int         B2_INVERT    = 6;
  localparam int         B2_LOCK_HI   = 5;
  localparam int         B2_LOCK_LO   = 3;
  localparam int         B2_PROG_P    = 2;
  localparam int         B2_FOUR      = 1;
  localparam int         B2_GUARD_HI  = 0;
  localparam logic [2:0] BIT_FIRST    = 3'h7;
  localparam logic [2:0] BIT_LAST     = 3'h0;

  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
  } fsr_pair_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } fsr_link_t;
endpackage : fsr_pkg

// file: hdl/fsr_status.sv
// Status register pair with serial status read engine.
// Assumes write-status data, latch and suspend events come from the
// command decoder on core_clk; link pins are asynchronous.
`timescale 1ns/1ns
module fsr_status (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // Serial link pins
  input  wire fsr_pkg::fsr_link_t link,
  output logic                 so,
  output logic                 so_oe,
  // Write protect pin, active low
  input  wire logic            wp_n,
  // Events from the rest of the device
  input  wire logic            op_active,
  input  wire logic            wpl_set,
  input  wire logic            wpl_clr,
  input  wire logic            erase_pause,
  input  wire logic            program_pause,
  input  wire logic            pause_resume,
  input  wire logic            power_cycle,
  // Status write request
  input  wire logic            wr_req,
  input  wire fsr_pkg::fsr_pair_t wr_data,
  output logic                 wr_done,
  output logic                 wr_refused,
  // Settings seen by the rest of the device
  output fsr_pkg::fsr_pair_t   cfg,
  output logic                 four_lane_select,
  output logic                 modify_permit
);
  import fsr_pkg::*;

  function automatic logic [7:0] pick_byte(input fsr_pair_t p,
                                           input logic      two);
    pick_byte = two ? p.two : p.one;
  endfunction : pick_byte

  // Link and pin synchronisers
  fsr_link_t link_s1_q;
  fsr_link_t link_s2_q;
  fsr_link_t link_s3_q;
  logic      wp_s1_q;
  logic      wp_s2_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_s1_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      link_s2_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      link_s3_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      // Pin idles high; a low reset value would fake a locked pin
      wp_s1_q   <= 1'b1;
      wp_s2_q   <= 1'b1;
    end else begin
      link_s1_q <= link;
      link_s2_q <= link_s1_q;
      link_s3_q <= link_s2_q;
      wp_s1_q   <= wp_n;
      wp_s2_q   <= wp_s1_q;
    end
  end

  logic selected;
  logic sck_rise;
  logic sck_fall;

  assign selected = ~link_s2_q.cs_n;
  assign sck_rise = selected & link_s2_q.sck & ~link_s3_q.sck;
  assign sck_fall = selected & ~link_s2_q.sck & link_s3_q.sck;

  // Status storage
  fsr_pair_t stat_q;
  fsr_pair_t stat_d;
  logic      wr_done_q;
  logic      wr_done_d;
  logic      wr_refused_q;
  logic      wr_refused_d;
  fsr_pair_t live;
  logic      lockdown;
  logic      pin_locked;
  logic      permit;

  always_comb begin
    live             = stat_q;
    live.one[B1_BUSY] = op_active;
  end

  assign lockdown   = stat_q.two[B2_GUARD_HI]
                      & ~stat_q.one[B1_GUARD_LO];
  assign pin_locked = ~stat_q.two[B2_GUARD_HI] & stat_q.one[B1_GUARD_LO]
                      & ~wp_s2_q;
  // Guard pair 11 is not described; treated as locked too
  assign permit     = stat_q.one[B1_WPL] & ~stat_q.two[B2_GUARD_HI]
                      & ~pin_locked;

  always_comb begin
    stat_d       = stat_q;
    wr_done_d    = 1'b0;
    wr_refused_d = 1'b0;
    if (wr_req && stat_q.one[B1_WPL]) begin
      if (permit) begin
        stat_d.one = (stat_q.one & ~WMASK_ONE)
                     | (wr_data.one & WMASK_ONE);
        stat_d.two = (stat_q.two & ~WMASK_TWO)
                     | (wr_data.two & WMASK_TWO);
        wr_done_d  = 1'b1;
      end else begin
        wr_refused_d = 1'b1;
      end
      stat_d.one[B1_WPL] = 1'b0;
    end
    if (wpl_clr) begin
      stat_d.one[B1_WPL] = 1'b0;
    end
    if (power_cycle) begin
      stat_d.one[B1_WPL] = 1'b0;
      if (lockdown) begin
        stat_d.two[B2_GUARD_HI] = 1'b0;
        stat_d.one[B1_GUARD_LO] = 1'b0;
      end
    end
    // Set wins over a clear in the same cycle
    if (wpl_set) begin
      stat_d.one[B1_WPL] = 1'b1;
    end
    if (pause_resume) begin
      stat_d.two[B2_ERASE_P] = 1'b0;
      stat_d.two[B2_PROG_P]  = 1'b0;
    end
    if (erase_pause) begin
      stat_d.two[B2_ERASE_P] = 1'b1;
    end
    if (program_pause) begin
      stat_d.two[B2_PROG_P] = 1'b1;
    end
    stat_d.one[B1_BUSY] = 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_q       <= '{one: RST_ONE, two: RST_TWO};
      wr_done_q    <= 1'b0;
      wr_refused_q <= 1'b0;
    end else begin
      stat_q       <= stat_d;
      wr_done_q    <= wr_done_d;
      wr_refused_q <= wr_refused_d;
    end
  end

  assign cfg              = stat_q;
  assign wr_done          = wr_done_q;
  assign wr_refused       = wr_refused_q;
  assign four_lane_select = stat_q.two[B2_FOUR];
  assign modify_permit    = stat_q.one[B1_WPL];

  // Serial read engine
  typedef enum logic [1:0] {
    fsr_idle,
    fsr_opcode,
    fsr_stream,
    fsr_skip
  } fsr_state_t;

  fsr_state_t state_q;
  fsr_state_t state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [6:0] op_q;
  logic [6:0] op_d;
  logic       sel_two_q;
  logic       sel_two_d;
  logic [7:0] byte_q;
  logic [7:0] byte_d;
  logic       so_q;
  logic       so_d;
  logic       oe_q;
  logic       oe_d;
  logic [7:0] opcode;
  logic [7:0] fresh;

  assign opcode = {op_q, link_s2_q.si};
  // Busy is read live, so polling works mid-operation
  assign fresh  = pick_byte(live, sel_two_q);

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    op_d      = op_q;
    sel_two_d = sel_two_q;
    byte_d    = byte_q;
    so_d      = so_q;
    oe_d      = oe_q;
    if (!selected) begin
      state_d = fsr_idle;
      oe_d    = 1'b0;
      so_d    = 1'b0;
    end else begin
      case (state_q)
        fsr_idle: begin
          state_d = fsr_opcode;
          cnt_d   = BIT_LAST;
          op_d    = 7'h00;
        end
        fsr_opcode: begin
          if (sck_rise) begin
            op_d  = opcode[6:0];
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == BIT_FIRST) begin
              cnt_d = BIT_FIRST;
              if (opcode == OP_READ_ONE) begin
                state_d   = fsr_stream;
                sel_two_d = 1'b0;
              end else if (opcode == OP_READ_TWO) begin
                state_d   = fsr_stream;
                sel_two_d = 1'b1;
              end else begin
                state_d = fsr_skip;
              end
            end
          end
        end
        fsr_stream: begin
          if (sck_fall) begin
            oe_d  = 1'b1;
            cnt_d = cnt_q - 3'h1;
            if (cnt_q == BIT_FIRST) begin
              byte_d = fresh;
              so_d   = fresh[7];
            end else begin
              so_d = byte_q[cnt_q];
            end
          end
        end
        fsr_skip: begin
          state_d = fsr_skip;
        end
        default: begin
          state_d = fsr_idle;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q   <= fsr_idle;
      cnt_q     <= BIT_LAST;
      op_q      <= 7'h00;
      sel_two_q <= 1'b0;
      byte_q    <= 8'h00;
      so_q      <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      op_q      <= op_d;
      sel_two_q <= sel_two_d;
      byte_q    <= byte_d;
      so_q      <= so_d;
      oe_q      <= oe_d;
    end
  end

  assign so    = so_q;
  assign so_oe = oe_q;

  // Checks
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic op_done;
  assign op_done = (state_q == fsr_opcode) && sck_rise
                   && (cnt_q == BIT_FIRST);

  so_release_a: assert property (
    !selected |=> !so_oe && (state_q == fsr_idle))
    else $error("output still driven after deselect");

  read_one_a: assert property (
    op_done && (opcode == OP_READ_ONE)
    |=> (state_q == fsr_stream) && !sel_two_q && (cnt_q == BIT_FIRST))
    else $error("byte one read not started");

  read_two_a: assert property (
    op_done && (opcode == OP_READ_TWO)
    |=> (state_q == fsr_stream) && sel_two_q && (cnt_q == BIT_FIRST))
    else $error("byte two read not started");

  wrap_back_a: assert property (
    (state_q == fsr_stream) && sck_fall && selected && (cnt_q == BIT_LAST)
    |=> (cnt_q == BIT_FIRST))
    else $error("bit index did not wrap");

  fresh_byte_a: assert property (
    (state_q == fsr_stream) && sck_fall && selected
    && (cnt_q == BIT_FIRST)
    |=> so_oe && (so == $past(fresh[7])) && (byte_q == $past(fresh)))
    else $error("stale status byte sent");

  pin_lock_a: assert property (
    wr_req && stat_q.one[B1_WPL] && pin_locked
    |=> wr_refused && !wr_done
        && ((stat_q.one & WMASK_ONE) == ($past(stat_q.one) & WMASK_ONE)))
    else $error("write passed hardware protection");

  power_lock_a: assert property (
    wr_req && stat_q.one[B1_WPL] && lockdown && !power_cycle
    |=> wr_refused ##0 lockdown)
    else $error("write passed lockdown");

  soft_write_a: assert property (
    wr_req && stat_q.one[B1_WPL] && !stat_q.one[B1_GUARD_LO]
    && !stat_q.two[B2_GUARD_HI] && !wpl_set && !pause_resume
    && !erase_pause && !program_pause && !power_cycle
    |=> wr_done && (stat_q.two == ((wr_data.two & WMASK_TWO)
        | ($past(stat_q.two) & ~WMASK_TWO))) && !stat_q.one[B1_WPL])
    else $error("unprotected write not applied");

  latch_gate_a: assert property (
    wr_req && !stat_q.one[B1_WPL] |=> !wr_done && !wr_refused)
    else $error("write acted without latch");

  unlock_a: assert property (
    power_cycle && lockdown
    |=> !stat_q.one[B1_GUARD_LO] && !stat_q.two[B2_GUARD_HI])
    else $error("power cycle left lockdown");

  pause_a: assert property (
    erase_pause |=> stat_q.two[B2_ERASE_P])
    else $error("erase pause flag not set");

  busy_poll_c: cover property (
    (state_q == fsr_stream) && !sel_two_q && op_active
    ##[1:300] (state_q == fsr_stream) && !op_active);
  two_wrap_c: cover property (
    (state_q == fsr_stream) && sel_two_q && sck_fall
    && (cnt_q == BIT_LAST));
  lock_refuse_c: cover property (wr_req && lockdown ##1 wr_refused);
  mid_byte_c: cover property (
    (state_q == fsr_stream) && (cnt_q == 3'h4) ##1 !selected);
endmodule : fsr_status

// file: testbench/fsr_host.sv
// SPI host model that frames status reads toward the device.
// Assumes xfer is called right after a core_clk rising edge.
`timescale 1ns/1ns
module fsr_host (
  // Clock
  input  wire logic          core_clk,
  // Link pins
  output fsr_pkg::fsr_link_t link,
  input  wire logic          so,
  input  wire logic          so_oe
);
  import fsr_pkg::*;
  logic idle_q = 1'b1;

  initial link <= 3'b100;

  // Data line is released between frames; toggle so nothing looks valid
  always @(posedge core_clk)
    if (idle_q)
      link.si <= ~link.si;

  task automatic xfer(input logic [7:0] op, input int n, input logic m3,
                      output logic [15:0] got, output logic oe);
    got = 16'h0000;
    oe = 1'b1;
    link.sck <= m3;
    @(posedge core_clk);
    link.cs_n <= 1'b0;
    idle_q <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 7; i >= 0; i--) begin
      link.si <= op[i];
      link.sck <= 1'b0;
      repeat (4) @(posedge core_clk);
      link.sck <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
    for (int i = 0; i < n; i++) begin
      link.sck <= 1'b0;
      repeat (4) @(posedge core_clk);
      link.sck <= 1'b1;
      // Sample late in the high phase, well clear of the output update
      repeat (3) @(posedge core_clk);
      // Undriven line reads as the inverse, so a float never looks valid
      got = {got[14:0], so_oe ? so : ~so};
      oe = oe & so_oe;
      @(posedge core_clk);
    end
    link.sck <= m3;
    repeat (4) @(posedge core_clk);
    link.cs_n <= 1'b1;
    idle_q <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : xfer
endmodule : fsr_host

// file: testbench/testbench.sv
// Self-checking bench for the status register block.
// Assumes fsr_host frames the serial reads; events pulse one cycle.
`timescale 1ns/1ns
module testbench;
  import fsr_pkg::*;
  localparam logic [5:0] E_SET = 6'h01;
  localparam logic [5:0] E_CLR = 6'h02;
  localparam logic [5:0] E_ERS = 6'h04;
  localparam logic [5:0] E_PRG = 6'h08;
  localparam logic [5:0] E_RES = 6'h10;
  localparam logic [5:0] E_PWR = 6'h20;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       wp_n = 1'b1;
  logic       op_active = 1'b0;
  logic       wr_req = 1'b0;
  logic [5:0] ev = 6'h00;
  fsr_pair_t  wr_data = 16'h0000;
  fsr_link_t  link;
  fsr_pair_t  cfg;
  logic       so, so_oe, wr_done, wr_refused;
  logic       four_lane_select, modify_permit;
  int         errors = 0;
  int         checks = 0;

  always #50 core_clk = ~core_clk;

  fsr_status u_dut (
    .core_clk(core_clk), .rst(rst), .link(link), .so(so),
    .so_oe(so_oe), .wp_n(wp_n), .op_active(op_active),
    .wpl_set(ev[0]), .wpl_clr(ev[1]), .erase_pause(ev[2]),
    .program_pause(ev[3]), .pause_resume(ev[4]), .power_cycle(ev[5]),
    .wr_req(wr_req), .wr_data(wr_data), .wr_done(wr_done),
    .wr_refused(wr_refused), .cfg(cfg),
    .four_lane_select(four_lane_select), .modify_permit(modify_permit)
  );

  fsr_host u_host (
    .core_clk(core_clk), .link(link), .so(so), .so_oe(so_oe)
  );

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic ev_pulse(input logic [5:0] m);
    ev <= m;
    @(posedge core_clk);
    ev <= 6'h00;
    @(posedge core_clk);
  endtask : ev_pulse

  task automatic wr(input fsr_pair_t d, input logic [1:0] er,
                    input fsr_pair_t ec);
    logic [1:0] r;
    r = 2'b00;
    wr_req <= 1'b1;
    wr_data <= d;
    @(posedge core_clk);
    wr_req <= 1'b0;
    repeat (2) begin
      @(negedge core_clk);
      r = r | {wr_done, wr_refused};
    end
    @(posedge core_clk);
    chk({14'h0000, r}, {14'h0000, er}, "write answer");
    chk(cfg, ec, "stored status");
    chk({15'h0000, modify_permit}, 16'h0000, "latch after write");
  endtask : wr

  task automatic rd(input logic [7:0] op, input int n, input logic m3,
                    input logic [15:0] exp);
    logic [15:0] got;
    logic        oe;
    u_host.xfer(op, n, m3, got, oe);
    chk(got, exp, "status bits");
    chk({15'h0000, oe}, 16'h0001, "drive enable");
    repeat (6) @(negedge core_clk);
    chk({14'h0000, so_oe, so}, 16'h0000, "released output");
    @(posedge core_clk);
  endtask : rd

  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    $display("BAD %0t run did not finish", $time);
    complete_run();
  end

  initial begin
    logic [15:0] got;
    logic        oe;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(OP_READ_ONE, 16, 1'b0, 16'h0000);
    rd(OP_READ_TWO, 16, 1'b1, 16'h0000);
    wr(16'hFFFF, 2'b00, 16'h0000);
    ev_pulse(E_SET);
    chk({15'h0000, modify_permit}, 16'h0001, "latch set");
    ev_pulse(E_CLR);
    wr(16'hFFFF, 2'b00, 16'h0000);
    ev_pulse(E_SET);
    op_active <= 1'b1;
    fork
      rd(OP_READ_ONE, 16, 1'b0, 16'h0302);
      begin
        repeat (100) @(posedge core_clk);
        op_active <= 1'b0;
      end
    join
    wr(16'hFFFE, 2'b10, 16'hFC7A);
    chk({15'h0000, four_lane_select}, 16'h0001, "four lanes");
    ev_pulse(E_ERS | E_PRG);
    rd(OP_READ_TWO, 16, 1'b0, 16'hFEFE);
    ev_pulse(E_RES);
    rd(OP_READ_TWO, 3, 1'b1, 16'h0003);
    wp_n <= 1'b0;
    ev_pulse(E_SET);
    wr(16'h0000, 2'b01, 16'hFC7A);
    wp_n <= 1'b1;
    ev_pulse(E_SET);
    wr(16'h0001, 2'b10, 16'h0001);
    ev_pulse(E_SET);
    wr(16'h0000, 2'b01, 16'h0001);
    ev_pulse(E_PWR);
    chk(cfg, 16'h0000, "power cycle");
    wp_n <= 1'b0;
    ev_pulse(E_SET);
    wr(16'h0400, 2'b10, 16'h0400);
    u_host.xfer(8'h15, 8, 1'b0, got, oe);
    chk({got[7:0], 7'h00, oe}, 16'hFF00, "other opcode");
    complete_run();
  end
endmodule : testbench
